/* hdl/eds_map.vh */
`ifndef EDS_MAP_VH
`define EDS_MAP_VH
`define EDS_ADDR_COUNT 12'h000
`define EDS_ADDR_TIMER 12'h004
`define EDS_ADDR_PRESET 12'h008
`define EDS_ADDR_CURRENT 12'h00C
`define EDS_ADDR_CTRL 12'h010
`define EDS_ADDR_STATUS 12'h014
`define EDS_ADDR_TBASE 12'h018
`define EDS_ADDR_BASEIDX 12'h01C
`define EDS_ADDR_CPS 12'h100
`define EDS_ADDR_EVSEL 12'h140
`define EDS_ADDR_PATTERN 12'h180
`define EDS_CTRL_RUNMODE 0
`define EDS_CTRL_RETAIN 1
`define EDS_STAT_DONE 0
`define EDS_RST_PRESET 16'h0001
`define EDS_RST_TBASE 16'h0064
`define EDS_RST_LAST 4'hF
`define EDS_TICK_NS 10000000
`define EDS_CLK_NS 50
`define EDS_TICK_CYCLES (`EDS_TICK_NS / `EDS_CLK_NS)
`define EDS_TB_MIN 16'h0001
`define EDS_TB_MAX 16'h270F
`define EDS_CPS_MAX 16'h270F
`define EDS_BASE_MAX 8'h4A
`define EDS_UNASSIGNED 5'h00
`endif

/* hdl/eds_sync.v */
`timescale 1ns/100ps
module eds_sync #(
  parameter WIDTH = 4
) (
  // clock
  input wire clock,
  input wire reset,
  input wire clockEnable,
  // data
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else if (clockEnable)
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

/* hdl/eds_timebase.v */
`timescale 1ns/100ps
`include "eds_map.vh"
module eds_timebase #(
  parameter TICK_CYCLES = `EDS_TICK_CYCLES
) (
  // clock
  input wire clock,
  input wire reset,
  input wire clockEnable,
  // control
  input wire [15:0] timeBase,
  input wire running,
  input wire restart,
  // result
  output reg countTick
);
  // 10 ms prescaler, then timebase divider in 10 ms units
  reg [31:0] preCount;
  reg [15:0] baseCount;
  wire hundredth = (preCount == TICK_CYCLES - 1);
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      preCount <= 32'h00000000;
      baseCount <= 16'h0000;
      countTick <= 1'b0;
    end
    else if (clockEnable)
    begin
      countTick <= 1'b0;
      if (restart)
      begin
        preCount <= 32'h00000000;
        baseCount <= 16'h0000;
      end
      else if (running)
      begin
        if (hundredth)
        begin
          preCount <= 32'h00000000;
          if (baseCount + 16'h0001 >= timeBase)
          begin
            baseCount <= 16'h0000;
            countTick <= 1'b1;
          end
          else
            baseCount <= baseCount + 16'h0001;
        end
        else
          preCount <= preCount + 32'h00000001;
      end
    end
  end
endmodule

/* hdl/eds_sequencer.v */
`timescale 1ns/100ps
`include "eds_map.vh"
// Behaviour
// - entering run mode without retain loads current step from preset step first
// - run on, reset off: current step waits event and/or runs timer
// - reset overrides run; holds preset step, ignores events, timer halted
// - run off mid-step freezes timer; resumes from same value
// - last step done sets completion flag, step stays at last
// - reset after completion clears flag and forces preset step
// - each jog rising edge in run mode advances one step when reset off
// - jog advance clears step timer; runs at once if run on
// - jog on last step moves to completed state, sets flag
// - sixteen steps, sixteen outputs, each bit with own destination point
// - outputs driven in run mode; preset pattern on run-mode entry without retain
// - step timer counts only while run on and event true
// - advance when step count equals programmed counts per step
// - one count per timebase; base 0.01-99.99 s; counts 0-9999
// - four status counters at base index 0-74; base bit is flag
// - preset counter writable anytime, used at next reset; rest read-only
// - each step takes at most one event contact reference
// - on step change outputs switch to new step pattern immediately
// - run off keeps output pattern unchanged
// - after completion run and jog ignored until reset or run entry without retain
// - retentive memory keeps counters; otherwise reinit to preset step
module eds_sequencer #(
  parameter STEPS = 16,
  parameter OUTS = 16,
  parameter EVENTS = 32,
  parameter TICK_CYCLES = `EDS_TICK_CYCLES
) (
  // clock and reset
  input wire clock,
  input wire reset,
  input wire clockEnable,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // ladder inputs
  input wire startIn,
  input wire jogIn,
  input wire resetIn,
  input wire [EVENTS-1:0] eventPoints,
  // drum outputs
  output reg [OUTS-1:0] drumOutputs,
  output reg [OUTS-1:0] outputsEnabled,
  output reg completionFlag
);
  // event selector index 0 is the unassigned code
  reg [15:0] stepCount;
  reg [15:0] stepTimer;
  reg [15:0] presetStep;
  reg [15:0] currentStep;
  reg [15:0] timeBase;
  reg [7:0] baseIndex;
  reg runMode;
  reg retain;
  reg [3:0] lastStep;
  reg [15:0] countsPerStep [0:STEPS-1];
  reg [4:0] eventSelect [0:STEPS-1];
  reg [OUTS-1:0] pattern [0:STEPS-1];
  reg runModeDelayed;
  reg jogDelayed;
  wire [2:0] ladderSync;
  wire [EVENTS-1:0] eventSync;
  wire countTick;
  integer i;

  eds_sync #(.WIDTH(3)) ladderSyncer (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .asyncIn({resetIn, jogIn, startIn}),
    .syncOut(ladderSync)
  );
  eds_sync #(.WIDTH(EVENTS)) eventSyncer (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .asyncIn(eventPoints),
    .syncOut(eventSync)
  );

  wire startOn = ladderSync[0];
  wire jogOn = ladderSync[1];
  wire resetOn = ladderSync[2];

  function [3:0] stepIndex;
    input [15:0] stepNumber;
    begin
      if (stepNumber == 16'h0000 || stepNumber > STEPS)
        stepIndex = 4'h0;
      else
        stepIndex = stepNumber[3:0] - 4'h1;
    end
  endfunction

  function [15:0] clampPreset;
    input [15:0] value;
    begin
      if (value == 16'h0000 || value > STEPS)
        clampPreset = 16'h0001;
      else
        clampPreset = value;
    end
  endfunction

  wire [3:0] curIdx = stepIndex(currentStep);
  wire [4:0] curEvent = eventSelect[curIdx];
  wire [15:0] curCounts = countsPerStep[curIdx];
  // single contact per step; unassigned means no event condition
  wire eventTrue = (curEvent == `EDS_UNASSIGNED) ? 1'b1 : eventSync[curEvent - 5'h01];
  wire timed = (curCounts != 16'h0000);
  wire runEntry = runMode & ~runModeDelayed;
  wire active = runMode & ~resetOn & ~completionFlag;
  wire running = active & startOn & eventTrue;
  wire jogEdge = jogOn & ~jogDelayed;
  // event-only steps advance as soon as the event is true
  wire timedDone = timed & countTick & running & (stepCount + 16'h0001 >= curCounts);
  wire eventDone = ~timed & running & (curEvent != `EDS_UNASSIGNED);
  wire advance = active & ((jogEdge) | timedDone | eventDone);
  wire atLast = (curIdx == lastStep);

  eds_timebase #(.TICK_CYCLES(TICK_CYCLES)) timebase (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .timeBase(timeBase),
    .running(running),
    .restart(advance | resetOn | runEntry),
    .countTick(countTick)
  );

  // drum state
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stepCount <= 16'h0000;
      stepTimer <= 16'h0000;
      currentStep <= `EDS_RST_PRESET;
      completionFlag <= 1'b0;
      runModeDelayed <= 1'b0;
      jogDelayed <= 1'b0;
    end
    else if (clockEnable)
    begin
      runModeDelayed <= runMode;
      jogDelayed <= jogOn;
      if (runEntry)
      begin
        if (!retain)
        begin
          currentStep <= clampPreset(presetStep);
          stepCount <= 16'h0000;
          stepTimer <= 16'h0000;
          completionFlag <= 1'b0;
        end
      end
      else if (runMode && resetOn)
      begin
        currentStep <= clampPreset(presetStep);
        stepCount <= 16'h0000;
        stepTimer <= 16'h0000;
        completionFlag <= 1'b0;
      end
      else if (advance)
      begin
        stepCount <= 16'h0000;
        stepTimer <= 16'h0000;
        if (atLast)
          completionFlag <= 1'b1;
        else
          currentStep <= currentStep + 16'h0001;
      end
      else if (running && countTick)
      begin
        stepCount <= stepCount + 16'h0001;
        stepTimer <= stepTimer + timeBase;
      end
    end
  end

  // outputs follow current step pattern in run mode only
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      drumOutputs <= {OUTS{1'b0}};
      outputsEnabled <= {OUTS{1'b0}};
    end
    else if (clockEnable)
    begin
      outputsEnabled <= {OUTS{runMode}};
      if (runEntry && !retain)
        drumOutputs <= pattern[stepIndex(clampPreset(presetStep))];
      else if (advance && !atLast)
        drumOutputs <= pattern[curIdx + 4'h1];
      else if (runMode && resetOn)
        drumOutputs <= pattern[stepIndex(clampPreset(presetStep))];
      else if (runMode && !advance)
        drumOutputs <= pattern[curIdx];
    end
  end

  // apb register file, zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  wire wrAccess = psel & penable & pwrite;
  wire inTable = (paddr >= `EDS_ADDR_CPS) && (paddr < `EDS_ADDR_PATTERN + 12'h040);
  wire [3:0] tableIdx = paddr[5:2];

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      presetStep <= `EDS_RST_PRESET;
      timeBase <= `EDS_RST_TBASE;
      baseIndex <= 8'h00;
      runMode <= 1'b0;
      retain <= 1'b0;
      lastStep <= `EDS_RST_LAST;
      for (i = 0; i < STEPS; i = i + 1)
      begin
        countsPerStep[i] <= 16'h0000;
        eventSelect[i] <= 5'h00;
        pattern[i] <= {OUTS{1'b0}};
      end
    end
    else if (clockEnable && wrAccess)
    begin
      case (paddr)
        `EDS_ADDR_PRESET: presetStep <= pwdata[15:0];
        `EDS_ADDR_CTRL:
        begin
          runMode <= pwdata[`EDS_CTRL_RUNMODE];
          retain <= pwdata[`EDS_CTRL_RETAIN];
          lastStep <= pwdata[11:8];
        end
        `EDS_ADDR_TBASE:
          if (pwdata[15:0] >= `EDS_TB_MIN && pwdata[15:0] <= `EDS_TB_MAX)
            timeBase <= pwdata[15:0];
        `EDS_ADDR_BASEIDX:
          if (pwdata[7:0] <= `EDS_BASE_MAX)
            baseIndex <= pwdata[7:0];
        default:
          if (inTable)
          begin
            case (paddr[7:6])
              2'h0: if (pwdata[15:0] <= `EDS_CPS_MAX) countsPerStep[tableIdx] <= pwdata[15:0];
              2'h1: eventSelect[tableIdx] <= pwdata[4:0];
              default: pattern[tableIdx] <= pwdata[OUTS-1:0];
            endcase
          end
      endcase
    end
  end

  always @*
  begin
    prdata = 32'h00000000;
    case (paddr)
      `EDS_ADDR_COUNT: prdata = {16'h0000, stepCount};
      `EDS_ADDR_TIMER: prdata = {16'h0000, stepTimer};
      `EDS_ADDR_PRESET: prdata = {16'h0000, presetStep};
      `EDS_ADDR_CURRENT: prdata = {16'h0000, currentStep};
      `EDS_ADDR_CTRL: prdata = {20'h00000, lastStep, 6'h00, retain, runMode};
      `EDS_ADDR_STATUS: prdata = {31'h00000000, completionFlag};
      `EDS_ADDR_TBASE: prdata = {16'h0000, timeBase};
      `EDS_ADDR_BASEIDX: prdata = {24'h000000, baseIndex};
      default:
        if (inTable)
        begin
          case (paddr[7:6])
            2'h0: prdata = {16'h0000, countsPerStep[tableIdx]};
            2'h1: prdata = {27'h0000000, eventSelect[tableIdx]};
            default: prdata = {{(32-OUTS){1'b0}}, pattern[tableIdx]};
          endcase
        end
    endcase
  end
endmodule

/* dv/eds_ladder.sv */
`timescale 1ns/100ps
module eds_ladder (
  // ladder levels
  output reg startIn,
  output reg jogIn,
  output reg resetIn,
  output reg [31:0] eventPoints,
  // clock
  input wire clock
);
  initial
  begin
    startIn = 1'h0;
    jogIn = 1'h0;
    resetIn = 1'h0;
    eventPoints = 32'h0;
  end
  // compound conditions arrive already merged into one relay bit
  task drive(input s, input r, input [31:0] e);
  begin
    @(posedge clock);
    startIn <= s;
    resetIn <= r;
    eventPoints <= e;
  end
  endtask
  // off-to-on edge held past the input synchroniser
  task jog;
  begin
    @(posedge clock);
    jogIn <= 1'h1;
    repeat (4) @(posedge clock);
    jogIn <= 1'h0;
    repeat (4) @(posedge clock);
  end
  endtask
endmodule

/* dv/eds_sequencer_assertions.sv */
`timescale 1ns/100ps
module eds_checker #(
  parameter OUTS = 16
) (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire startIn,
  input wire jogIn,
  input wire resetIn,
  input wire [OUTS-1:0] drumOutputs,
  input wire [OUTS-1:0] outputsEnabled,
  input wire completionFlag
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ready_high_a: assert property (pready && !pslverr) else $error("apb answer bad");
  enables_even_a: assert property (outputsEnabled == 0 || &outputsEnabled) else $error("enables split");
  idle_freeze_a: assert property ((!startIn && !jogIn && !resetIn && !psel)[*5] |=>
    $stable(drumOutputs)) else $error("outputs moved while idle");
  reset_hold_a: assert property ((resetIn && outputsEnabled[0] && !psel)[*5] |=>
    !completionFlag && $stable(drumOutputs)) else $error("reset not holding");
  done_hold_a: assert property (completionFlag && !resetIn && !$past(resetIn) &&
    !$past(resetIn, 2) && !psel |=> completionFlag && $stable(drumOutputs)) else $error("done lost");
  jog_step_a: assert property ($rose(jogIn) && !resetIn && !completionFlag && outputsEnabled[0]
    |-> ##[2:6] ($changed(drumOutputs) || completionFlag)) else $error("jog ignored");
  hole_zero_a: assert property (psel && !pwrite && paddr == 12'h020 |-> prdata == 32'h0)
    else $error("hole read nonzero");
  done_clear_a: assert property ($fell(completionFlag) |-> $past(resetIn, 3) || $past(psel, 2))
    else $error("flag fell alone");
  cover property ($rose(completionFlag));
  cover property ($fell(completionFlag));
  cover property ($rose(jogIn) && outputsEnabled[0]);
endmodule
bind eds_sequencer eds_checker #(.OUTS(OUTS)) eds_checker_i (.clock(clock), .reset(reset), .psel(psel),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .startIn(startIn),
  .jogIn(jogIn), .resetIn(resetIn), .drumOutputs(drumOutputs), .outputsEnabled(outputsEnabled),
  .completionFlag(completionFlag));

/* dv/test_event_drum_sequencer.sv */
`timescale 1ns/100ps
module test_event_drum_sequencer;
  reg clock, reset, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata, rv, cv;
  wire pready, pslverr, completionFlag, startIn, jogIn, resetIn;
  wire [31:0] prdata, eventPoints;
  wire [15:0] drumOutputs, outputsEnabled;
  integer n_mismatch, comparisons, i;
  eds_sequencer #(.TICK_CYCLES(2)) eds_sequencer_i (.clock(clock), .reset(reset), .clockEnable(1'h1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .startIn(startIn), .jogIn(jogIn), .resetIn(resetIn),
    .eventPoints(eventPoints), .drumOutputs(drumOutputs), .outputsEnabled(outputsEnabled),
    .completionFlag(completionFlag));
  eds_ladder eds_ladder_i (.clock(clock), .startIn(startIn), .jogIn(jogIn), .resetIn(resetIn),
    .eventPoints(eventPoints));
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  task wrap_up;
  begin
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
  begin
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    rv = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  end
  endtask
  task rc(input string nm, input [11:0] a, input [31:0] e);
  begin
    apb(a, 1'h0, 32'h0);
    chk(nm, e, rv);
  end
  endtask
  function [31:0] pat(input [31:0] s);
    pat = s * 32'h0101;
  endfunction
  task regs_s;
  begin
    rc("preset", 12'h008, 32'h1);
    rc("base", 12'h018, 32'h64);
    apb(12'h00C, 1'h1, 32'h5);
    rc("step", 12'h00C, 32'h1);
    rc("hole", 12'h020, 32'h0);
    apb(12'h018, 1'h1, 32'h0);
    rc("base", 12'h018, 32'h64);
    apb(12'h018, 1'h1, 32'h1);
    rc("base", 12'h018, 32'h1);
    for (i = 0; i < 16; i = i + 1)
    begin
      apb(12'h100 + 12'(i * 4), 1'h1, 32'h0);
      apb(12'h140 + 12'(i * 4), 1'h1, 32'h0);
      apb(12'h180 + 12'(i * 4), 1'h1, pat(i + 1));
    end
    apb(12'h104, 1'h1, 32'h4);
    apb(12'h144, 1'h1, 32'h1);
    apb(12'h108, 1'h1, 32'h270F);
    apb(12'h148, 1'h1, 32'h1);
  end
  endtask
  task jog_s;
  begin
    apb(12'h008, 1'h1, 32'h3);
    apb(12'h010, 1'h1, 32'h301);
    rc("step", 12'h00C, 32'h3);
    chk("outs", pat(3), {16'h0, drumOutputs});
    chk("enable", 32'hFFFF, {16'h0, outputsEnabled});
    eds_ladder_i.jog;
    rc("step", 12'h00C, 32'h4);
    chk("outs", pat(4), {16'h0, drumOutputs});
    rc("timer", 12'h004, 32'h0);
    eds_ladder_i.jog;
    chk("flag", 32'h1, {31'h0, completionFlag});
    eds_ladder_i.jog;
    rc("step", 12'h00C, 32'h4);
    chk("outs", pat(4), {16'h0, drumOutputs});
  end
  endtask
  task reset_s;
  begin
    apb(12'h008, 1'h1, 32'h2);
    chk("flag", 32'h1, {31'h0, completionFlag});
    eds_ladder_i.drive(1'h1, 1'h1, 32'h1);
    repeat (30) @(posedge clock);
    chk("flag", 32'h0, {31'h0, completionFlag});
    rc("step", 12'h00C, 32'h2);
    rc("count", 12'h000, 32'h0);
    chk("outs", pat(2), {16'h0, drumOutputs});
    eds_ladder_i.drive(1'h0, 1'h0, 32'h0);
  end
  endtask
  task timed_s;
  begin
    eds_ladder_i.drive(1'h1, 1'h0, 32'h0);
    repeat (30) @(posedge clock);
    rc("count", 12'h000, 32'h0);
    eds_ladder_i.drive(1'h1, 1'h0, 32'h1);
    for (i = 0; i < 300 && rv !== 32'h3; i = i + 1)
      apb(12'h00C, 1'h0, 32'h0);
    chk("step", 32'h3, rv);
    repeat (10) @(posedge clock);
    eds_ladder_i.drive(1'h0, 1'h0, 32'h1);
    repeat (6) @(posedge clock);
    apb(12'h000, 1'h0, 32'h0);
    cv = rv;
    repeat (30) @(posedge clock);
    rc("frozen", 12'h000, cv);
    chk("outs", pat(3), {16'h0, drumOutputs});
    eds_ladder_i.drive(1'h1, 1'h0, 32'h1);
    repeat (20) @(posedge clock);
    apb(12'h000, 1'h0, 32'h0);
    chk("resumed", 32'h1, {31'h0, rv > cv});
  end
  endtask
  task retain_s;
  begin
    apb(12'h010, 1'h1, 32'h300);
    rc("step", 12'h00C, 32'h3);
    chk("enable", 32'h0, {16'h0, outputsEnabled});
    apb(12'h010, 1'h1, 32'h303);
    rc("step", 12'h00C, 32'h3);
    chk("enable", 32'hFFFF, {16'h0, outputsEnabled});
    apb(12'h010, 1'h1, 32'h300);
    apb(12'h010, 1'h1, 32'h301);
    rc("step", 12'h00C, 32'h2);
    chk("outs", pat(2), {16'h0, drumOutputs});
  end
  endtask
  initial
  begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rv = 32'h0;
    cv = 32'h0;
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    regs_s;
    jog_s;
    reset_s;
    timed_s;
    retain_s;
    wrap_up;
  end
endmodule
